//--- src/usct_core.sv
// Serial transceiver core with Avalon-MM register slave
//
// Decided for this implementation: register access over Avalon-MM.
module usct_core
    import usct_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic rx_pin,
    output logic tx_pin,
    input wire logic cts_n,
    output logic rts_n,
    output logic sclk_o,
    output logic sclk_oe,
    output logic irq
);
    typedef struct packed {
        usct_regs_t r;
        usct_phase_t tph;
        logic [3:0] tsub;
        logic [3:0] tbit;
        logic [9:0] tsh;
        logic tx;
        logic sclk;
        usct_phase_t rph;
        logic [3:0] rsub;
        logic [3:0] rbit;
        logic [8:0] rsh;
        logic [8:0] rbuf;
        logic [1:0] rsync;
    } usct_state_t;
    usct_state_t s_q, s_d;
    usct_fmt_t fmt;
    usct_sclk_t sck;
    logic tick, bus_hit, last_sub, rlast_sub, rmid;
    logic [3:0] nbits, tick_max;
    logic [8:0] pword, rword;
    logic [15:0] wr16;

    // Even or odd parity of the low data bits
    function automatic logic parity(input logic [8:0] v, input logic [3:0] n,
                                    input logic odd);
        logic p;
        p = odd;
        for (int i = 0; i < 9; i++) begin
            if (i < int'(n)) p = p ^ v[i];
        end
        return p;
    endfunction

    // Frame format decode from control registers
    always_comb begin
        fmt.en = s_q.r.ctl1[C1_UE];
        fmt.nine = s_q.r.ctl1[C1_M];
        fmt.par_en = s_q.r.ctl1[C1_PCE];
        fmt.par_odd = s_q.r.ctl1[C1_PS];
        fmt.stop = s_q.r.ctl2[C2_STOP+1:C2_STOP];
        fmt.oversample_half_bit = s_q.r.ctl1[C1_OVERSAMPLE_HALF_BIT];
        sck.clken = s_q.r.ctl2[C2_CLKEN];
        sck.clock_idle_level = s_q.r.ctl2[C2_CLOCK_IDLE_LEVEL];
        sck.clock_capture_edge = s_q.r.ctl2[C2_CLOCK_CAPTURE_EDGE];
        sck.lbcl = s_q.r.ctl2[C2_LBCL];
    end

    usct_baud u_baud (
        .clk_sys(clk_sys),
        .rst(rst),
        .enable(fmt.en),
        .divisor(s_q.r.baud),
        .oversample_half_bit(fmt.oversample_half_bit),
        .tick(tick)
    );

    // Bit count per frame: 8 or 9, parity included
    assign nbits = fmt.nine ? 4'h9 : 4'h8;
    // 16 or 8 ticks per bit
    assign tick_max = fmt.oversample_half_bit ? TICKS8 : TICKS16;
    assign last_sub = tick && s_q.tsub == tick_max;
    assign rlast_sub = tick && s_q.rsub == tick_max;
    assign rmid = tick && s_q.rsub == (fmt.oversample_half_bit ? MID8 : MID16);
    assign wr16 = avs_writedata[15:0];
    assign bus_hit = avs_address[1:0] == 2'b00;

    // Parity overwrites the top bit of the word
    always_comb begin
        pword = s_q.r.transmit_buffer;
        if (!fmt.nine) pword[8] = 1'b0;
        if (fmt.par_en) begin
            pword[nbits-4'h1] = parity(s_q.r.transmit_buffer, nbits - 4'h1, fmt.par_odd);
        end
        rword = fmt.nine ? s_q.rsh : {1'b0, s_q.rsh[8:1]};
    end

    // Main next-state logic
    always_comb begin
        s_d = s_q;
        s_d.r.rvalid = 1'b0;
        s_d.rsync = {s_q.rsync[0], rx_pin};
        // Register writes
        if (avs_write && bus_hit) begin
            unique case (avs_address)
                ADDR_STATUS: s_d.r.status = s_q.r.status & ~(wr16 & ST_W1C);
                ADDR_DATA: begin
                    s_d.r.transmit_buffer = wr16[8:0];
                    s_d.r.status[ST_TXE] = 1'b0;
                    s_d.r.status[ST_TC] = 1'b0;
                end
                ADDR_BAUD: s_d.r.baud = wr16;
                ADDR_CTL1: s_d.r.ctl1 = wr16;
                ADDR_CTL2: s_d.r.ctl2 = wr16;
                ADDR_CTL3: s_d.r.ctl3 = wr16;
                ADDR_GTP: s_d.r.gtp = wr16;
                ADDR_MASK: s_d.r.mask = wr16;
                default: ;
            endcase
        end
        // Register reads, data read empties the buffer
        if (avs_read) begin
            s_d.r.rvalid = 1'b1;
            s_d.r.rdata = RST_ZERO;
            if (bus_hit) begin
                unique case (avs_address)
                    ADDR_STATUS: s_d.r.rdata = s_q.r.status;
                    ADDR_DATA: begin
                        s_d.r.rdata = {7'h00, s_q.rbuf};
                        s_d.r.status[ST_RXNE] = 1'b0;
                    end
                    ADDR_BAUD: s_d.r.rdata = s_q.r.baud;
                    ADDR_CTL1: s_d.r.rdata = s_q.r.ctl1;
                    ADDR_CTL2: s_d.r.rdata = s_q.r.ctl2;
                    ADDR_CTL3: s_d.r.rdata = s_q.r.ctl3;
                    ADDR_GTP: s_d.r.rdata = s_q.r.gtp;
                    ADDR_MASK: s_d.r.rdata = s_q.r.mask;
                    default: s_d.r.rdata = RST_ZERO;
                endcase
            end
        end
        // Transmitter
        if (tick) s_d.tsub = (s_q.tsub == tick_max) ? 4'h0 : s_q.tsub + 4'h1;
        unique case (s_q.tph)
            USCT_IDLE: begin
                s_d.tx = 1'b1;
                s_d.sclk = sck.clock_idle_level;
                s_d.tsub = 4'h0;
                // Load only after the previous frame
                if (fmt.en && s_q.r.ctl1[C1_TE] && !s_q.r.status[ST_TXE] &&
                    !(s_q.r.ctl3[C3_CTSE] && cts_n)) begin
                    s_d.tsh = {1'b1, pword};
                    // A data write in the load cycle keeps the buffer full
                    s_d.r.status[ST_TXE] = !(avs_write && bus_hit &&
                                             avs_address == ADDR_DATA);
                    s_d.tph = USCT_START;
                end
            end
            USCT_START: begin
                s_d.tx = 1'b0;
                if (last_sub) begin
                    s_d.tph = USCT_DATA;
                    s_d.tbit = 4'h0;
                end
            end
            USCT_DATA: begin
                s_d.tx = s_q.tsh[0];
                // Synchronous clock: toggle at sub-tick MID8 and at bit end, last bit gated
                if (tick && (s_q.tsub == MID8 || s_q.tsub == tick_max) &&
                    (sck.lbcl || s_q.tbit != nbits - 4'h1)) begin
                    s_d.sclk = ((s_q.tsub == MID8) ^ sck.clock_capture_edge) ^ sck.clock_idle_level;
                end
                if (last_sub) begin
                    s_d.tsh = {1'b1, s_q.tsh[9:1]};
                    s_d.tbit = s_q.tbit + 4'h1;
                    if (s_q.tbit == nbits - 4'h1) begin
                        s_d.tph = USCT_STOP;
                        s_d.tbit = 4'h0;
                        s_d.sclk = sck.clock_idle_level;
                    end
                end
            end
            USCT_STOP: begin
                s_d.tx = 1'b1;
                // Stop length from control: 1 or 2 bits
                if (last_sub) begin
                    s_d.tbit = s_q.tbit + 4'h1;
                    if (s_q.tbit[1:0] == (fmt.stop == STOP_TWO ? 2'h1 : 2'h0)) begin
                        s_d.tph = USCT_IDLE;
                        s_d.r.status[ST_TC] = s_q.r.status[ST_TXE];
                    end
                end
            end
        endcase
        // Receiver
        if (tick) s_d.rsub = (s_q.rsub == tick_max) ? 4'h0 : s_q.rsub + 4'h1;
        unique case (s_q.rph)
            USCT_IDLE: begin
                s_d.rsub = 4'h0;
                if (fmt.en && s_q.r.ctl1[C1_RE] && !s_q.rsync[1]) begin
                    s_d.rph = USCT_START;
                end
            end
            USCT_START: begin
                if (rmid && s_q.rsync[1]) s_d.rph = USCT_IDLE; // glitch
                if (rlast_sub) begin
                    s_d.rph = USCT_DATA;
                    s_d.rbit = 4'h0;
                end
            end
            USCT_DATA: begin
                if (rmid) begin
                    s_d.rsh = {s_q.rsync[1], s_q.rsh[8:1]};
                    s_d.rbit = s_q.rbit + 4'h1;
                end
                if (rlast_sub && s_q.rbit == nbits) s_d.rph = USCT_STOP;
            end
            USCT_STOP: begin
                if (rmid) begin
                    s_d.rph = USCT_IDLE;
                    // Full buffer keeps the old word, new one is lost
                    if (s_q.r.status[ST_RXNE]) begin
                        s_d.r.status[ST_ORE] = 1'b1;
                    end else begin
                        s_d.rbuf = rword;
                    end
                    s_d.r.status[ST_RXNE] = 1'b1;
                    if (!s_q.rsync[1]) s_d.r.status[ST_FE] = 1'b1;
                    if (fmt.par_en && parity(rword, nbits, fmt.par_odd)) begin
                        s_d.r.status[ST_PE] = 1'b1;
                    end
                end
            end
        endcase
        if (!fmt.en) begin
            s_d.tph = USCT_IDLE;
            s_d.rph = USCT_IDLE;
        end
        // Pin level follows the phase being entered
        unique case (s_d.tph)
            USCT_IDLE: s_d.tx = 1'b1;
            USCT_START: s_d.tx = 1'b0;
            USCT_DATA: s_d.tx = s_d.tsh[0];
            USCT_STOP: s_d.tx = 1'b1;
        endcase
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.r.status <= RST_STATUS;
            s_q.tx <= 1'b1;
            s_q.rsync <= 2'b11;
        end else begin
            s_q <= s_d;
        end
    end

    // Outputs
    assign avs_waitrequest = (avs_read || avs_write) ? !s_q.r.rvalid && avs_read : 1'b0;
    assign avs_readdata = {16'h0000, s_q.r.rdata};
    assign tx_pin = s_q.tx;
    assign rts_n = s_q.r.ctl3[C3_RTSE] && s_q.r.status[ST_RXNE];
    assign sclk_oe = sck.clken;
    assign sclk_o = sck.clken ? s_q.sclk : sck.clock_idle_level;
    assign irq = |(s_q.r.status & s_q.r.mask);

    AST_TX_IDLE_HIGH: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.tph == USCT_IDLE |-> tx_pin) else $error("tx not idle high");
    AST_START_LOW: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.tph == USCT_START |-> !tx_pin) else $error("start bit not low");
    AST_LOAD_AFTER_FRAME: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.tph != USCT_IDLE && !last_sub |=> $stable(s_q.tsh))
        else $error("shift reg loaded mid frame");
    AST_TXE_ON_LOAD: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.tph == USCT_IDLE ##1 s_q.tph == USCT_START |-> s_q.r.status[ST_TXE])
        else $error("buffer not freed on load");
    AST_CLK_OE: assert property (@(posedge clk_sys) disable iff (rst)
        sclk_oe == s_q.r.ctl2[C2_CLKEN]) else $error("clock oe wrong");
    AST_CLK_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.tph == USCT_IDLE ##1 s_q.tph == USCT_IDLE && $stable(sck.clock_idle_level)
        |-> sclk_o == sck.clock_idle_level) else $error("clock idle level");
    AST_CTS_BLOCK: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.tph == USCT_IDLE && s_q.r.ctl3[C3_CTSE] && cts_n |=> s_q.tph == USCT_IDLE)
        else $error("sent while cts high");
    AST_TX_DISABLED: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.tph == USCT_IDLE && !s_q.r.ctl1[C1_TE] |=> s_q.tph == USCT_IDLE)
        else $error("sent while disabled");
    AST_RX_DISABLED: assert property (@(posedge clk_sys) disable iff (rst)
        s_q.rph == USCT_IDLE && !s_q.r.ctl1[C1_RE] |=> s_q.rph == USCT_IDLE)
        else $error("received while disabled");
    AST_IRQ: assert property (@(posedge clk_sys) disable iff (rst)
        irq == |(s_q.r.status & s_q.r.mask)) else $error("irq mismatch");
    COV_TX: cover property (@(posedge clk_sys) s_q.tph == USCT_STOP ##1 s_q.tph == USCT_IDLE);
    COV_RX: cover property (@(posedge clk_sys) $rose(s_q.r.status[ST_RXNE]));
    COV_PAR: cover property (@(posedge clk_sys) $rose(s_q.r.status[ST_PE]));
endmodule

//--- src/usct_pkg.sv
// Package: register map, field positions, timing and carrier types
//
// Behaviour
// - receive shifts pin bits in LSB first
// - data read returns the receive buffer
// - data write fills buffer, loads after frame
// - parity replaces the top data bit
// - word length selects 8 or 9 bits
// - divisor holds integer and fraction parts
// - oversample-by-8 mode via control bit
// - stop bit count is programmable
// - receiver and transmitter enabled independently
// - optional RTS/CTS hardware flow control
// - clock pin driven only when enabled
// - polarity sets idle clock level
// - phase selects capture edge
// - last-bit setting gates final clock pulse
package usct_pkg;
    localparam logic [4:0] ADDR_STATUS = 5'h00;
    localparam logic [4:0] ADDR_DATA = 5'h04;
    localparam logic [4:0] ADDR_BAUD = 5'h08;
    localparam logic [4:0] ADDR_CTL1 = 5'h0c;
    localparam logic [4:0] ADDR_CTL2 = 5'h10;
    localparam logic [4:0] ADDR_CTL3 = 5'h14;
    localparam logic [4:0] ADDR_GTP = 5'h18;
    localparam logic [4:0] ADDR_MASK = 5'h1c;
    // Status bits
    localparam int ST_PE = 0;
    localparam int ST_FE = 1;
    localparam int ST_ORE = 3;
    localparam int ST_RXNE = 5;
    localparam int ST_TC = 6;
    localparam int ST_TXE = 7;
    localparam logic [15:0] ST_W1C = 16'h006b;
    // Control one bits
    localparam int C1_RE = 2;
    localparam int C1_TE = 3;
    localparam int C1_PS = 9;
    localparam int C1_PCE = 10;
    localparam int C1_M = 12;
    localparam int C1_UE = 13;
    localparam int C1_OVERSAMPLE_HALF_BIT = 15;
    // Control two bits
    localparam int C2_LBCL = 8;
    localparam int C2_CLOCK_CAPTURE_EDGE = 9;
    localparam int C2_CLOCK_IDLE_LEVEL = 10;
    localparam int C2_CLKEN = 11;
    localparam int C2_STOP = 12;
    // Control three bits
    localparam int C3_RTSE = 8;
    localparam int C3_CTSE = 9;
    localparam int FRAC_W = 4;
    localparam logic [15:0] RST_ZERO = 16'h0000;
    localparam logic [15:0] RST_STATUS = 16'h00c0;
    localparam logic [3:0] TICKS16 = 4'hf;
    localparam logic [3:0] TICKS8 = 4'h7;
    localparam logic [3:0] MID16 = 4'h7;
    localparam logic [3:0] MID8 = 4'h3;
    localparam logic [1:0] STOP_TWO = 2'h2;

    typedef enum logic [1:0] {
        USCT_IDLE = 2'b00,
        USCT_START = 2'b01,
        USCT_DATA = 2'b11,
        USCT_STOP = 2'b10
    } usct_phase_t;

    typedef struct packed {
        logic en;
        logic nine;
        logic par_en;
        logic par_odd;
        logic [1:0] stop;
        logic oversample_half_bit;
    } usct_fmt_t;

    // Synchronous clock options
    typedef struct packed {
        logic clken;
        logic clock_idle_level;
        logic clock_capture_edge;
        logic lbcl;
    } usct_sclk_t;

    typedef struct packed {
        logic [15:0] status;
        logic [15:0] mask;
        logic [15:0] baud;
        logic [15:0] ctl1;
        logic [15:0] ctl2;
        logic [15:0] ctl3;
        logic [15:0] gtp;
        logic [8:0] transmit_buffer;
        logic [15:0] rdata;
        logic rvalid;
    } usct_regs_t;
endpackage

//--- src/usct_baud.sv
// Fractional baud tick generator for the oversampling clock
module usct_baud
    import usct_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic enable,
    input wire logic [15:0] divisor,
    input wire logic oversample_half_bit,
    output logic tick
);
    typedef struct packed {
        logic [11:0] cnt;
        logic [3:0] acc;
        logic tick;
    } usct_baud_st_t;
    usct_baud_st_t s_q, s_d;
    logic [11:0] mant;
    logic [3:0] frac;
    logic [4:0] sum;
    logic [3:0] wrap;

    // Integer part divides, fraction spreads extra cycles
    always_comb begin
        mant = divisor[15:FRAC_W];
        // In 8x mode only three fraction bits count
        frac = oversample_half_bit ? {1'b0, divisor[2:0]} : divisor[3:0];
        wrap = oversample_half_bit ? 4'h8 : 4'h0;
        sum = {1'b0, s_q.acc} + {1'b0, frac};
        s_d = s_q;
        s_d.tick = 1'b0;
        if (!enable || mant == 12'h000) begin
            s_d.cnt = 12'h000;
            s_d.acc = 4'h0;
        end else if (s_q.cnt == 12'h000) begin
            s_d.tick = 1'b1;
            s_d.acc = sum[3:0];
            if (oversample_half_bit && sum[3]) begin
                s_d.acc = sum[3:0] - wrap;
            end
            // Carry adds one extra clock this period
            if (sum[4] || (oversample_half_bit && sum[3])) begin
                s_d.cnt = mant;
            end else begin
                s_d.cnt = mant - 12'h001;
            end
        end else begin
            s_d.cnt = s_q.cnt - 12'h001;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
endmodule

//--- test/usct_remote.sv
// Remote serial device facing the transceiver pins
module usct_remote
    import usct_pkg::*;
(
    input wire logic clk_sys,
    input wire logic tx_pin,
    output logic rx_pin,
    output logic cts_n
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle line high, sending allowed
    initial begin
        rx_pin = 1'b1;
        cts_n = 1'b0;
    end

    // Flow control level shown to the transceiver
    task automatic clear(input logic v);
        cts_n <= v;
    endtask

    // Start low, data LSB first, one high stop
    task automatic put(input logic [8:0] d, input int nb, input int bc);
        rx_pin <= 1'b0;
        repeat (bc) @(posedge clk_sys);
        for (int i = 0; i < nb; i++) begin
            rx_pin <= d[i];
            repeat (bc) @(posedge clk_sys);
        end
        rx_pin <= 1'b1;
        repeat (bc) @(posedge clk_sys);
    endtask

    // Catch one frame, sampling each bit near its centre
    task automatic grab(input int nb, input int bc, output logic [8:0] d,
                        output time t, output bit ok);
        int i;
        d = 9'h000;
        for (i = 0; i < 20000; i++) begin
            @(posedge clk_sys);
            if (tx_pin === 1'b0) break;
        end
        t = $time;
        repeat (bc / 2) @(posedge clk_sys);
        ok = (i < 20000) && (tx_pin === 1'b0);
        for (i = 0; i < nb; i++) begin
            repeat (bc) @(posedge clk_sys);
            d[i] = tx_pin;
        end
        repeat (bc) @(posedge clk_sys);
        ok = ok && (tx_pin === 1'b1);
    endtask
endmodule

//--- test/test_usct_core.sv
// Self-checking bench for the serial transceiver core
module test_usct_core;
    import usct_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk_sys;
    logic rst;
    logic [4:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic rx_pin;
    logic tx_pin;
    logic cts_n;
    logic rts_n;
    logic sclk_o;
    logic sclk_oe;
    logic irq;
    logic sclk_prev;
    logic [15:0] rd;
    logic [8:0] fd;
    time t0;
    time t1;
    bit ok;
    int n_mismatch;
    int tests_run;
    int n_rise;
    int r0;
    int lows;
    logic [4:0] regs [6] = '{ADDR_BAUD, ADDR_CTL1, ADDR_CTL2, ADDR_CTL3,
                             ADDR_GTP, ADDR_MASK};
    logic [15:0] pc1 [4] = '{16'h240c, 16'h260c, 16'h340c, 16'h300c};
    logic [8:0] pd [4] = '{9'h083, 9'h083, 9'h1ff, 9'h1a5};
    logic [8:0] pe [4] = '{9'h003, 9'h083, 9'h0ff, 9'h1a5};

    usct_core uut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin),
        .tx_pin(tx_pin), .cts_n(cts_n), .rts_n(rts_n), .sclk_o(sclk_o),
        .sclk_oe(sclk_oe), .irq(irq));
    usct_remote rem (.clk_sys(clk_sys), .tx_pin(tx_pin), .rx_pin(rx_pin),
        .cts_n(cts_n));

    // 50 MHz clock
    always #10 clk_sys = ~clk_sys;

    // Count rising edges of the synchronous clock
    always @(posedge clk_sys) begin
        sclk_prev <= sclk_o;
        if (sclk_o === 1'b1 && sclk_prev === 1'b0)
            n_rise <= n_rise + 1;
    end

    // Verdict and end of run
    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input string w, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", w, e, g);
        end
    endtask

    // One bus access, held until waitrequest is seen low
    task automatic bus(input logic w, input logic [4:0] a,
                       input logic [15:0] d);
        int i;
        avs_address <= a;
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {16'h0000, d};
        for (i = 0; i < 50; i++) begin
            @(posedge clk_sys);
            if (avs_waitrequest === 1'b0) break;
        end
        rd = avs_readdata[15:0];
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        if (i == 50) begin
            n_mismatch++;
            final_report();
        end
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdchk(input string w, input logic [4:0] a,
                         input logic [15:0] m, input logic [15:0] e);
        bus(1'b0, a, 16'h0000);
        chk(w, e, rd & m);
    endtask

    task automatic quiet(input int n);
        lows = 0;
        repeat (n) begin
            @(posedge clk_sys);
            if (tx_pin !== 1'b1) lows++;
        end
    endtask

    task automatic frame(input string w, input int nb, input int bc,
                         input logic [8:0] e);
        rem.grab(nb, bc, fd, t0, ok);
        chk({w, " stop"}, 16'h0001, 16'(ok));
        chk(w, {7'h00, e}, {7'h00, fd});
        repeat (bc) @(posedge clk_sys);
    endtask

    // Two queued words, start-to-start spacing in whole bits
    task automatic two(input logic [8:0] a, input logic [8:0] b,
                       input int bc, input int bits);
        wr(ADDR_DATA, {7'h00, a});
        wr(ADDR_DATA, {7'h00, b});
        rem.grab(8, bc, fd, t0, ok);
        chk("first", {7'h00, a}, {7'h00, fd});
        rem.grab(8, bc, fd, t1, ok);
        chk("second", {7'h00, b}, {7'h00, fd});
        chk("spacing", 16'(bits), 16'((t1 - t0 + bc * 10) / (bc * 20)));
        repeat (bc) @(posedge clk_sys);
    endtask

    task automatic done(input string n);
        $display("test %s finished", n);
    endtask

    // Main sequence
    initial begin
        clk_sys = 1'b0;
        rst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0000_0000;
        repeat (5) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        rdchk("status", ADDR_STATUS, 16'hffff, RST_STATUS);
        foreach (regs[k]) rdchk("reset", regs[k], 16'hffff, 16'h0000);
        rdchk("unaligned", 5'h02, 16'hffff, 16'h0000);
        wr(5'h0d, 16'hffff);
        rdchk("ctl1", ADDR_CTL1, 16'hffff, 16'h0000);
        wr(ADDR_GTP, 16'hbeef);
        rdchk("gtp", ADDR_GTP, 16'hffff, 16'hbeef);
        done("registers");
        wr(ADDR_BAUD, 16'h0020);
        wr(ADDR_CTL1, 16'h200c);
        two(9'h0a5, 9'h03c, 32, 10);
        wr(ADDR_CTL2, 16'h2000);
        two(9'h011, 9'h022, 32, 11);
        wr(ADDR_CTL2, 16'h0000);
        done("buffered send");
        for (int k = 0; k < 4; k++) begin
            wr(ADDR_CTL1, pc1[k]);
            wr(ADDR_DATA, {7'h00, pd[k]});
            frame("format", (k < 2) ? 8 : 9, 32, pe[k]);
        end
        wr(ADDR_CTL1, 16'h200c);
        wr(ADDR_BAUD, 16'h0028);
        two(9'h05a, 9'h0c3, 40, 10);
        done("format and divisor");
        wr(ADDR_BAUD, 16'h0020);
        rem.put(9'h096, 8, 32);
        rdchk("rx flag", ADDR_STATUS, 16'h0020, 16'h0020);
        quiet(2);
        chk("irq masked", 16'h0000, 16'(irq));
        wr(ADDR_MASK, 16'h0020);
        quiet(2);
        chk("irq", 16'h0001, 16'(irq));
        rdchk("rx data", ADDR_DATA, 16'h01ff, 16'h0096);
        quiet(2);
        chk("irq cleared", 16'h0000, 16'(irq));
        rdchk("rx flag", ADDR_STATUS, 16'h0020, 16'h0000);
        wr(ADDR_MASK, 16'h0000);
        wr(ADDR_STATUS, 16'h0040);
        rdchk("tc clear", ADDR_STATUS, 16'h00c0, 16'h0080);
        wr(ADDR_CTL1, 16'h8000);
        wr(ADDR_BAUD, 16'h0020);
        wr(ADDR_CTL1, 16'ha00c);
        rem.put(9'h03b, 8, 16);
        rdchk("rx 8x", ADDR_DATA, 16'h01ff, 16'h003b);
        wr(ADDR_CTL1, 16'h200c);
        done("receive and interrupt");
        wr(ADDR_CTL3, 16'h0200);
        rem.clear(1'b1);
        wr(ADDR_DATA, 16'h006e);
        quiet(400);
        chk("cts hold", 16'h0000, 16'(lows));
        rem.clear(1'b0);
        frame("cts", 8, 32, 9'h06e);
        wr(ADDR_CTL3, 16'h0100);
        rem.put(9'h012, 8, 32);
        quiet(2);
        chk("rts full", 16'h0001, 16'(rts_n));
        rdchk("rts data", ADDR_DATA, 16'h01ff, 16'h0012);
        quiet(2);
        chk("rts free", 16'h0000, 16'(rts_n));
        wr(ADDR_CTL3, 16'h0000);
        done("flow control");
        for (int l = 0; l < 2; l++) begin
            wr(ADDR_CTL2, 16'h0800 | (16'(l) << 10) | (16'(l) << 8));
            quiet(2);
            chk("clk oe", 16'h0001, 16'(sclk_oe));
            chk("clk idle", 16'(l), 16'(sclk_o));
            r0 = n_rise;
            wr(ADDR_DATA, 16'h000f);
            frame("sync", 8, 32, 9'h00f);
            chk("pulses", 16'(7 + l), 16'(n_rise - r0));
        end
        wr(ADDR_CTL2, 16'h0000);
        quiet(2);
        chk("clk off", 16'h0000, 16'(sclk_oe));
        done("synchronous clock");
        wr(ADDR_CTL1, 16'h2004);
        wr(ADDR_DATA, 16'h0055);
        quiet(400);
        chk("tx off", 16'h0000, 16'(lows));
        wr(ADDR_CTL1, 16'h2008);
        rem.put(9'h055, 8, 32);
        rdchk("rx off", ADDR_STATUS, 16'h0020, 16'h0000);
        done("enables");
        final_report();
    end
endmodule
